//--- bench/agu_mem_model.sv
// Memory bus sink that logs each address the block issues
`timescale 1ns/1ns
module agu_mem_model
    import agu_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Address buses
    input wire logic [23:0] xab,
    input wire logic [23:0] yab,
    input wire logic [23:0] pab,
    input wire logic xab_valid,
    input wire logic yab_valid,
    input wire logic pab_valid,
    // Observed access
    output logic obs_valid,
    output agu_bus_e obs_bus,
    output logic [23:0] obs_addr
);
    // Latch one access per cycle, X ahead of Y ahead of P
    always_ff @(posedge mclk) begin
        obs_valid <= xab_valid | yab_valid | pab_valid;
        obs_bus <= xab_valid ? AGU_BUS_X : (yab_valid ? AGU_BUS_Y : AGU_BUS_P);
        obs_addr <= xab_valid ? xab : (yab_valid ? yab : pab);
    end
endmodule

//--- bench/testbench.sv
// Self-checking bench for the address generation block
`timescale 1ns/1ns
module testbench;
    import agu_pkg::*;
    // Design inputs
    logic mclk, resetn, stack_memory_select, sixteen_bit_compat, ea_valid;
    logic reg_wr, stack_push, stack_pull;
    agu_mode_e ea_mode;
    agu_bus_e ea_bus;
    agu_imm_e imm_kind;
    agu_regsel_e reg_sel;
    logic [2:0] ea_reg, reg_idx;
    logic [23:0] op_word, ext_word, program_counter, reg_wdata;
    // Design outputs and bus observer
    logic [23:0] reg_rdata, xab, yab, pab, imm_data, stack_addr, obs_addr;
    logic xab_valid, yab_valid, pab_valid, stack_in_y, obs_valid;
    agu_bus_e obs_bus;
    // Shadow registers, expectations and counters
    logic [23:0] rr[8], nn[8], mm[8];
    logic [25:0] expq[$];
    logic [31:0] seed;
    logic [23:0] t;
    int miscompares, num_checks;

    agu_core dut (.mclk, .resetn, .stack_memory_select, .sixteen_bit_compat, .ea_valid,
        .ea_mode, .ea_bus, .ea_reg, .op_word, .ext_word, .program_counter, .imm_kind,
        .reg_wr, .reg_sel, .reg_idx, .reg_wdata, .stack_push, .stack_pull, .reg_rdata,
        .xab, .yab, .pab, .xab_valid, .yab_valid, .pab_valid, .imm_data, .stack_addr,
        .stack_in_y);

    agu_mem_model partner (.mclk, .xab, .yab, .pab, .xab_valid, .yab_valid, .pab_valid,
        .obs_valid, .obs_bus, .obs_addr);

    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Pseudo-random words
    function automatic logic [23:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[23:0];
    endfunction

    // Bit reversal for the reverse-carry model
    function automatic logic [23:0] rev(logic [23:0] x);
        logic [23:0] y;
        for (int j = 0; j < 24; j++)
            y[j] = x[23 - j];
        return y;
    endfunction

    // Pointer update under a modifier; modulo case covers steps of one
    function automatic logic [23:0] upd(logic [23:0] r, logic [23:0] d, logic [23:0] m);
        logic [23:0] k, o;
        k = m | (m >> 1);
        k = k | (k >> 2);
        k = k | (k >> 4);
        k = k | (k >> 8);
        o = (r & k) + d;
        if (m == 24'h0) return rev(rev(r) + rev(d));
        if (m[15:0] == 16'hffff) return r + d;
        if (o == m + 24'h1) o = 24'h0;
        if (o == 24'hffffff) o = m;
        return (r & ~k) | o;
    endfunction

    task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Register move into the block, mirrored in the shadow copy
    task automatic wreg(agu_regsel_e s, logic [2:0] i, logic [23:0] v);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_sel = s;
        reg_idx = i;
        reg_wdata = v;
        @(negedge mclk);
        reg_wr = 1'b0;
        if (sixteen_bit_compat) v = v & 24'h00ffff;
        if (s == AGU_REG_ADDR) rr[i] = v;
        if (s == AGU_REG_OFFSET) nn[i] = v;
        if (s == AGU_REG_MOD) mm[i] = v;
    endtask

    // Select a register and compare the read one cycle on
    task automatic rdchk(agu_regsel_e s, logic [2:0] i, logic [23:0] v);
        @(negedge mclk);
        reg_sel = s;
        reg_idx = i;
        @(negedge mclk);
        check("register read", reg_rdata, v);
    endtask

    // One address calculation with its expected address and write-back
    task automatic ea(agu_mode_e md, agu_bus_e b, logic [2:0] i);
        logic [23:0] r, a, nr, w, pc, x, cm;
        r = rr[i];
        w = xorshift();
        pc = xorshift();
        x = xorshift();
        cm = sixteen_bit_compat ? 24'h00ffff : 24'hffffff;
        a = r;
        nr = r;
        case (md)
            AGU_POST_INC: nr = upd(r, 24'h1, mm[i]);
            AGU_POST_DEC: nr = upd(r, 24'hffffff, mm[i]);
            AGU_POST_INC_N: nr = upd(r, nn[i], mm[i]);
            AGU_POST_DEC_N: nr = upd(r, -nn[i], mm[i]);
            AGU_INDEXED: a = upd(r, nn[i], mm[i]);
            AGU_PRE_DEC: a = upd(r, 24'hffffff, mm[i]);
            AGU_SHORT_DISP: a = r + {{17{w[6]}}, w[6:0]};
            AGU_LONG_DISP: a = r + x;
            AGU_PC_SHORT: a = pc + {{15{w[8]}}, w[8:0]};
            AGU_PC_LONG: a = pc + x;
            AGU_PC_REG: a = pc + r;
            AGU_ABS_SHORT: a = {18'h0, w[5:0]};
            AGU_JUMP_SHORT: a = {12'h0, w[11:0]};
            AGU_IO_SHORT: a = {18'h3ffff, w[5:0]};
            default: a = r;
        endcase
        if (md == AGU_PRE_DEC) nr = a;
        a = a & cm;
        nr = nr & cm;
        expq.push_back({b, a});
        @(negedge mclk);
        ea_valid = 1'b1;
        ea_mode = md;
        ea_bus = b;
        ea_reg = i;
        op_word = w;
        ext_word = x;
        program_counter = pc;
        imm_kind = agu_imm_e'(w[13:12] % 2'h3);
        @(negedge mclk);
        ea_valid = 1'b0;
        if (imm_kind == AGU_IMM_MOVE8) check("imm8", imm_data, {16'h0, w[7:0]});
        if (imm_kind == AGU_IMM_LOOP12) check("imm12", imm_data, {12'h0, w[11:0]});
        rr[i] = nr;
        rdchk(AGU_REG_ADDR, i, nr);
        rdchk(AGU_REG_OFFSET, i, nn[i]);
    endtask

    // Load every pointer and offset with random words
    task automatic load_all();
        for (int i = 0; i < 8; i++) begin
            wreg(AGU_REG_ADDR, i[2:0], xorshift());
            wreg(AGU_REG_OFFSET, i[2:0], xorshift());
            rdchk(AGU_REG_ADDR, i[2:0], rr[i]);
        end
    endtask

    // Pair each observed bus access with the oldest expectation
    always @(negedge mclk) begin
        if (obs_valid === 1'b1) begin
            if (expq.size() == 0) begin
                miscompares++;
                $display("BAD bus access expected none seen %h", obs_addr);
            end else begin
                check("bus select", {22'h0, obs_bus}, {22'h0, expq[0][25:24]});
                check("effective address", obs_addr, expq[0][23:0]);
                void'(expq.pop_front());
            end
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        seed = 32'hfd40;
        {resetn, stack_memory_select, sixteen_bit_compat, ea_valid} = 4'h0;
        {reg_wr, stack_push, stack_pull} = 3'h0;
        ea_mode = AGU_NONE;
        ea_bus = AGU_BUS_X;
        imm_kind = AGU_IMM_NONE;
        reg_sel = AGU_REG_ADDR;
        {ea_reg, reg_idx, op_word, ext_word, program_counter, reg_wdata} = 102'h0;
        for (int i = 0; i < 8; i++) begin
            {rr[i], nn[i], mm[i]} = {48'h0, 24'hffffff};
        end
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        resetn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rdchk(AGU_REG_MOD, i[2:0], 24'hffffff);
        end
        $display("test reset values done");
        for (int c = 0; c < 2; c++) begin
            sixteen_bit_compat = c[0];
            load_all();
            for (int k = 1; k < 16; k++) begin
                t = xorshift();
                ea(agu_mode_e'(k), (k == 14) ? AGU_BUS_P : agu_bus_e'({1'b0, t[3]}), t[2:0]);
            end
        end
        $display("test addressing modes done");
        sixteen_bit_compat = 1'b0;
        ea(AGU_POST_INC, AGU_BUS_X, 3'h1);
        ea(AGU_PRE_DEC, AGU_BUS_Y, 3'h1);
        ea(AGU_INDEXED, AGU_BUS_X, 3'h1);
        ea(AGU_IO_SHORT, AGU_BUS_X, 3'h1);
        ea(AGU_PC_SHORT, AGU_BUS_P, 3'h1);
        ea(AGU_NO_UPDATE, AGU_BUS_Y, 3'h1);
        ea(AGU_NONE, AGU_BUS_Y, 3'h1);
        $display("test linear bus modes done");
        wreg(AGU_REG_MOD, 3'h3, 24'h0);
        wreg(AGU_REG_MOD, 3'h5, 24'h4);
        wreg(AGU_REG_ADDR, 3'h5, 24'h00000c);
        rdchk(AGU_REG_MOD, 3'h5, 24'h4);
        ea(AGU_POST_INC, AGU_BUS_X, 3'h3);
        ea(AGU_POST_DEC, AGU_BUS_Y, 3'h3);
        ea(AGU_POST_INC_N, AGU_BUS_X, 3'h3);
        ea(AGU_POST_INC, AGU_BUS_Y, 3'h5);
        ea(AGU_POST_DEC, AGU_BUS_X, 3'h5);
        ea(AGU_PC_REG, AGU_BUS_X, 3'h5);
        $display("test modifier arithmetic done");
        stack_memory_select = 1'b1;
        wreg(AGU_REG_EP, 3'h0, 24'h000100);
        @(negedge mclk);
        check("stack side", {23'h0, stack_in_y}, 24'h1);
        check("stack address", stack_addr, 24'h000100);
        stack_push = 1'b1;
        @(negedge mclk);
        stack_push = 1'b0;
        rdchk(AGU_REG_EP, 3'h0, 24'h000101);
        check("stack address", stack_addr, 24'h000101);
        stack_pull = 1'b1;
        stack_memory_select = 1'b0;
        @(negedge mclk);
        stack_pull = 1'b0;
        check("stack address", stack_addr, 24'h000100);
        rdchk(AGU_REG_EP, 3'h0, 24'h000100);
        check("stack side", {23'h0, stack_in_y}, 24'h0);
        $display("test stack pointer done");
        for (int w = 0; w < 10 && expq.size() != 0; w++)
            @(negedge mclk);
        if (expq.size() != 0) miscompares++;
        final_report();
    end
endmodule

//--- rtl/agu_core.sv
// Address generation unit: register triplets, stack pointer and effective addresses
//
// Overview of operation
// (RL1) Stack area in X or Y per mode bit
// (RL2) Stack pointer is 24-bit, readable, writable
// (RL3) Stack pointer left unset; software loads first
// (RL4) Eight 24-bit offset registers, one per pointer
// (RL5) Reset loads all modifiers with all ones
// (RL6) Modifier picks linear, modulo or reverse-carry
// (RL7) No update: address used, register unchanged
// (RL8) Post increment by one under modifier
// (RL9) Post decrement by one under modifier
// (RL10) Post increment by offset, offset unchanged
// (RL11) Post decrement by offset, offset unchanged
// (RL12) Indexed: address plus offset, no writes
// (RL13) Pre decrement, write back, then access
// (RL14) Short displacement: 7-bit signed, sign-extended
// (RL15) Long displacement adds extension word
// (RL16) PC relative: linear, ignores offset, modifier
// (RL17) Short PC displacement 9 bits, sign-extended
// (RL18) PC plus address register, register unchanged
// (RL19) Immediate short data zero-extended, 8 or 12
// (RL20) Absolute short: 6-bit zero-extended
// (RL21) Short jump: 12-bit zero-extended
// (RL22) I/O short: 6-bit one-extended
// (RL23) Compat mode clears upper eight bits; the stack pointer and stack_addr keep all 24 bits
// (RL24) Modifier zero selects reverse carry
// (RL25) Modulo: modifier holds modulus minus one
`timescale 1ns/1ns
`include "agu_params.svh"
module agu_core
    import agu_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Mode bits
    input wire logic stack_memory_select,
    input wire logic sixteen_bit_compat,
    // Decoded instruction
    input wire logic ea_valid,
    input wire agu_mode_e ea_mode,
    input wire agu_bus_e ea_bus,
    input wire logic [2:0] ea_reg,
    input wire logic [23:0] op_word,
    input wire logic [23:0] ext_word,
    input wire logic [23:0] program_counter,
    input wire agu_imm_e imm_kind,
    // Register move port
    input wire logic reg_wr,
    input wire agu_regsel_e reg_sel,
    input wire logic [2:0] reg_idx,
    input wire logic [23:0] reg_wdata,
    // Stack extension access
    input wire logic stack_push,
    input wire logic stack_pull,
    // Outputs
    output logic [23:0] reg_rdata,
    output logic [23:0] xab,
    output logic [23:0] yab,
    output logic [23:0] pab,
    output logic xab_valid,
    output logic yab_valid,
    output logic pab_valid,
    output logic [23:0] imm_data,
    output logic [23:0] stack_addr,
    output logic stack_in_y
);
    logic [23:0] addr_q [`AGU_NREG];
    logic [23:0] addr_d [`AGU_NREG];
    logic [23:0] offs_q [`AGU_NREG];
    logic [23:0] offs_d [`AGU_NREG];
    logic [23:0] modr_q [`AGU_NREG];
    logic [23:0] modr_d [`AGU_NREG];
    logic [23:0] ep_q, ep_d;
    logic [23:0] ea_d, imm_d, rd_d, stack_addr_d;
    logic xv_d, yv_d, pv_d, sy_d;
    logic [23:0] xab_q, yab_q, pab_q, imm_q, rd_q, stack_addr_q;
    logic xv_q, yv_q, pv_q, sy_q;
    logic [23:0] r, n, m, upd, sc_mask;

    // Bit reversal for the reverse-carry adder
    function automatic logic [23:0] rev24(input logic [23:0] v);
        logic [23:0] o;
        o = '0;
        for (int i = 0; i < 24; i++) begin
            o[i] = v[23 - i];
        end
        return o;
    endfunction

    // Modulo-aware update of pointer by signed step
    function automatic logic [23:0] modify(input logic [23:0] base, input logic [23:0] step,
                                           input logic [23:0] mv);
        logic [23:0] sum, lo_mask, ofs, lim, res;
        sum = base + step;
        lo_mask = '0;
        ofs = '0;
        lim = '0;
        res = sum;
        if (mv[15:0] == `AGU_MOD_LINEAR) begin
            res = sum; // see (RL6)
        end else if (mv[15:0] == `AGU_MOD_REVCARRY) begin
            res = rev24(rev24(base) + rev24(step)); // see (RL24)
        end else if (mv[15] == 1'b0) begin
            // Buffer aligned to next power of two above the modifier value
            lo_mask = {8'h00, mv[15:0]};
            for (int i = 0; i < 16; i++) begin
                lo_mask = lo_mask | (lo_mask >> 1);
            end
            lim = {8'h00, mv[15:0]};
            ofs = (base & lo_mask) + step;
            if (step[23] == 1'b0 && (ofs & ~lo_mask) == 24'h000000 && ofs > lim) begin
                ofs = ofs - lim - 24'h000001;
            end else if (step[23] == 1'b0 && (ofs & ~lo_mask) != 24'h000000) begin
                ofs = ofs - lim - 24'h000001;
            end else if (step[23] == 1'b1 && ofs[23] == 1'b1) begin
                ofs = ofs + lim + 24'h000001;
            end
            res = (base & ~lo_mask) | (ofs & lo_mask); // see (RL25)
        end else begin
            // Multiple wrap-around: keep upper bits, wrap low field
            lo_mask = {10'h000, mv[13:0]};
            res = (base & ~lo_mask) | (sum & lo_mask);
        end
        return res;
    endfunction

    // Effective address calculation and register update
    always_comb begin
        addr_d = addr_q;
        offs_d = offs_q;
        modr_d = modr_q;
        ep_d = ep_q; // see (RL3)
        sc_mask = sixteen_bit_compat ? `AGU_SC_MASK : 24'hffffff;
        r = addr_q[ea_reg];
        n = offs_q[ea_reg]; // see (RL4)
        m = modr_q[ea_reg];
        upd = r;
        ea_d = xab_q;
        xv_d = 1'b0;
        yv_d = 1'b0;
        pv_d = 1'b0;
        if (ea_valid) begin
            unique case (ea_mode)
                AGU_NONE: ea_d = r;
                AGU_NO_UPDATE: ea_d = r; // see (RL7)
                AGU_POST_INC: begin
                    ea_d = r;
                    upd = modify(r, 24'h000001, m); // see (RL8)
                end
                AGU_POST_DEC: begin
                    ea_d = r;
                    upd = modify(r, 24'hffffff, m); // see (RL9)
                end
                AGU_POST_INC_N: begin
                    ea_d = r;
                    upd = modify(r, n, m); // see (RL10)
                end
                AGU_POST_DEC_N: begin
                    ea_d = r;
                    upd = modify(r, 24'h000000 - n, m); // see (RL11)
                end
                AGU_INDEXED: ea_d = modify(r, n, m); // see (RL12)
                AGU_PRE_DEC: begin
                    upd = modify(r, 24'hffffff, m); // see (RL13)
                    ea_d = upd;
                end
                AGU_SHORT_DISP: begin
                    ea_d = r + {{17{op_word[6]}}, op_word[6:0]}; // see (RL14)
                end
                AGU_LONG_DISP: ea_d = r + ext_word; // see (RL15)
                AGU_PC_SHORT: begin
                    ea_d = program_counter + {{15{op_word[8]}}, op_word[8:0]}; // see (RL17)
                end
                AGU_PC_LONG: ea_d = program_counter + ext_word; // see (RL16)
                AGU_PC_REG: ea_d = program_counter + r; // see (RL18)
                AGU_ABS_SHORT: ea_d = {18'h00000, op_word[5:0]}; // see (RL20)
                AGU_JUMP_SHORT: ea_d = {12'h000, op_word[11:0]}; // see (RL21)
                AGU_IO_SHORT: ea_d = {18'h3ffff, op_word[5:0]}; // see (RL22)
            endcase
            ea_d = ea_d & sc_mask; // see (RL23)
            // Only the updating modes write back, so a stale upper byte survives a plain use
            if (ea_mode inside {AGU_POST_INC, AGU_POST_DEC, AGU_POST_INC_N, AGU_POST_DEC_N,
                                AGU_PRE_DEC}) begin
                addr_d[ea_reg] = upd & sc_mask; // see (RL7)
            end
            xv_d = (ea_bus == AGU_BUS_X);
            yv_d = (ea_bus == AGU_BUS_Y);
            pv_d = (ea_bus == AGU_BUS_P);
        end
        // Register moves win over the pointer update in the same cycle
        if (reg_wr) begin
            unique case (reg_sel)
                AGU_REG_ADDR: addr_d[reg_idx] = reg_wdata & sc_mask; // see (RL23)
                AGU_REG_OFFSET: offs_d[reg_idx] = reg_wdata & sc_mask;
                AGU_REG_MOD: modr_d[reg_idx] = reg_wdata & sc_mask;
                AGU_REG_EP: ep_d = reg_wdata; // see (RL2)
            endcase
        end else if (stack_push) begin
            ep_d = ep_q + 24'h000001;
        end else if (stack_pull) begin
            ep_d = ep_q - 24'h000001;
        end
        unique case (reg_sel)
            AGU_REG_ADDR: rd_d = addr_q[reg_idx];
            AGU_REG_OFFSET: rd_d = offs_q[reg_idx];
            AGU_REG_MOD: rd_d = modr_q[reg_idx];
            AGU_REG_EP: rd_d = ep_q;
        endcase
        // Stack extension address: push uses the free slot, pull the last item
        stack_addr_d = stack_pull ? ep_q - 24'h000001 : ep_q;
        sy_d = stack_memory_select; // see (RL1)
        // Zero-extended immediate short data
        unique case (imm_kind)
            AGU_IMM_MOVE8: imm_d = {16'h0000, op_word[7:0]}; // see (RL19)
            AGU_IMM_LOOP12: imm_d = {12'h000, op_word[11:0]}; // see (RL19)
            default: imm_d = 24'h000000;
        endcase
    end

    // Register state; stack pointer is not reset
    always_ff @(posedge mclk) begin
        ep_q <= ep_d; // see (RL3)
        if (!resetn) begin
            for (int i = 0; i < `AGU_NREG; i++) begin
                addr_q[i] <= 24'h000000;
                offs_q[i] <= 24'h000000;
                modr_q[i] <= `AGU_MOD_RESET; // see (RL5)
            end
            xab_q <= 24'h000000;
            yab_q <= 24'h000000;
            pab_q <= 24'h000000;
            xv_q <= 1'b0;
            yv_q <= 1'b0;
            pv_q <= 1'b0;
            imm_q <= 24'h000000;
            rd_q <= 24'h000000;
            stack_addr_q <= 24'h000000;
            sy_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            offs_q <= offs_d;
            modr_q <= modr_d;
            xab_q <= xv_d ? ea_d : xab_q;
            yab_q <= yv_d ? ea_d : yab_q;
            pab_q <= pv_d ? ea_d : pab_q;
            xv_q <= xv_d;
            yv_q <= yv_d;
            pv_q <= pv_d;
            imm_q <= imm_d;
            rd_q <= rd_d;
            stack_addr_q <= stack_addr_d;
            sy_q <= sy_d;
        end
    end

    assign xab = xab_q;
    assign yab = yab_q;
    assign pab = pab_q;
    assign xab_valid = xv_q;
    assign yab_valid = yv_q;
    assign pab_valid = pv_q;
    assign imm_data = imm_q;
    assign reg_rdata = rd_q;
    assign stack_addr = stack_addr_q;
    assign stack_in_y = sy_q;

    // Checks on the address datapath
    property p_mod_reset;
        @(posedge mclk) !resetn |=> modr_q[0] == `AGU_MOD_RESET && modr_q[7] == `AGU_MOD_RESET;
    endproperty
    a_mod_reset: assert property (p_mod_reset) else $error("modifier not all ones"); // see (RL5)
    property p_noupd;
        @(posedge mclk) disable iff (!resetn)
        ea_valid && ea_mode == AGU_NO_UPDATE && !reg_wr |=> addr_q[$past(ea_reg)] == $past(r);
    endproperty
    a_noupd: assert property (p_noupd) else $error("no-update changed register"); // see (RL7)
    property p_postinc_lin;
        @(posedge mclk) disable iff (!resetn)
        ea_valid && ea_mode == AGU_POST_INC && ea_bus == AGU_BUS_X && !reg_wr
            && m == 24'hffffff && !sixteen_bit_compat
        |=> xab == $past(r) && addr_q[$past(ea_reg)] == $past(r) + 24'h000001;
    endproperty
    a_postinc_lin: assert property (p_postinc_lin) else $error("post increment wrong"); // see (RL8)
    property p_predec_lin;
        @(posedge mclk) disable iff (!resetn)
        ea_valid && ea_mode == AGU_PRE_DEC && ea_bus == AGU_BUS_Y && !reg_wr
            && m == 24'hffffff && !sixteen_bit_compat
        |=> yab == $past(r) - 24'h000001 && addr_q[$past(ea_reg)] == yab;
    endproperty
    a_predec_lin: assert property (p_predec_lin) else $error("pre decrement wrong"); // see (RL13)
    property p_indexed;
        @(posedge mclk) disable iff (!resetn)
        ea_valid && ea_mode == AGU_INDEXED && ea_bus == AGU_BUS_X && !reg_wr
            && m == 24'hffffff && !sixteen_bit_compat
        |=> xab == $past(r) + $past(n) && addr_q[$past(ea_reg)] == $past(r);
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong"); // see (RL12)
    property p_io_short;
        @(posedge mclk) disable iff (!resetn)
        ea_valid && ea_mode == AGU_IO_SHORT && ea_bus == AGU_BUS_X && !sixteen_bit_compat
        |=> xab[23:6] == 18'h3ffff && xab[5:0] == $past(op_word[5:0]);
    endproperty
    a_io_short: assert property (p_io_short) else $error("io short address wrong"); // see (RL22)
    property p_pc_short;
        @(posedge mclk) disable iff (!resetn)
        ea_valid && ea_mode == AGU_PC_SHORT && ea_bus == AGU_BUS_P && !sixteen_bit_compat
        |=> pab == $past(program_counter) + {{15{$past(op_word[8])}}, $past(op_word[8:0])};
    endproperty
    a_pc_short: assert property (p_pc_short) else $error("pc relative wrong"); // see (RL17)
    property p_sc_mask;
        @(posedge mclk) disable iff (!resetn)
        ea_valid && ea_bus == AGU_BUS_X && sixteen_bit_compat |=> xab[23:16] == 8'h00;
    endproperty
    a_sc_mask: assert property (p_sc_mask) else $error("compat upper bits set"); // see (RL23)
    property p_stack_sel;
        @(posedge mclk) disable iff (!resetn)
        stack_memory_select |=> stack_in_y;
    endproperty
    a_stack_sel: assert property (p_stack_sel) else $error("stack memory select wrong"); // see (RL1)
    c_postinc: cover property (@(posedge mclk) ea_valid && ea_mode == AGU_POST_INC);
    c_revcarry: cover property (@(posedge mclk) ea_valid && ea_mode == AGU_POST_INC_N
                                && m == 24'h000000);
    c_modulo: cover property (@(posedge mclk) ea_valid && ea_mode == AGU_POST_INC
                              && m[15] == 1'b0 && m[15:0] != 16'h0000);
endmodule

//--- shared/agu_params.svh
// Register count, modifier codes, compat mask, modifier reset value and widths of the address generation block
`ifndef AGU_PARAMS_SVH
`define AGU_PARAMS_SVH
`define AGU_W 24
`define AGU_NREG 8
`define AGU_MOD_RESET 24'hffffff
`define AGU_MOD_LINEAR 16'hffff
`define AGU_MOD_REVCARRY 16'h0000
`define AGU_SC_MASK 24'h00ffff
`define AGU_SHORT_DISP_W 7
`define AGU_PC_DISP_W 9
`define AGU_IMM8_W 8
`define AGU_IMM12_W 12
`define AGU_ABS_SHORT_W 6
`define AGU_IO_SHORT_W 6
`define AGU_JUMP_W 12
`endif

//--- shared/agu_pkg.sv
// Types shared by the address generation block
package agu_pkg;
    typedef enum logic [3:0] {
        AGU_NONE,
        AGU_NO_UPDATE,
        AGU_POST_INC,
        AGU_POST_DEC,
        AGU_POST_INC_N,
        AGU_POST_DEC_N,
        AGU_INDEXED,
        AGU_PRE_DEC,
        AGU_SHORT_DISP,
        AGU_LONG_DISP,
        AGU_PC_SHORT,
        AGU_PC_LONG,
        AGU_PC_REG,
        AGU_ABS_SHORT,
        AGU_JUMP_SHORT,
        AGU_IO_SHORT
    } agu_mode_e;
    typedef enum logic [1:0] {
        AGU_BUS_X,
        AGU_BUS_Y,
        AGU_BUS_P
    } agu_bus_e;
    typedef enum logic [1:0] {
        AGU_IMM_NONE,
        AGU_IMM_MOVE8,
        AGU_IMM_LOOP12
    } agu_imm_e;
    typedef enum logic [1:0] {
        AGU_REG_ADDR,
        AGU_REG_OFFSET,
        AGU_REG_MOD,
        AGU_REG_EP
    } agu_regsel_e;
endpackage
